// [rtl/serial_api_frame_codec_pkg.sv]
// Constants, state types and helpers shared by the serial frame codec
package serial_api_frame_codec_pkg;

    // Mode selector values
    localparam logic [1:0]  MODE_TRANSPARENT = 2'h0;
    localparam logic [1:0]  MODE_FRAMED      = 2'h1;
    localparam logic [1:0]  MODE_ESCAPED     = 2'h2;

    // Special byte values
    localparam logic [7:0]  START_DELIM      = 8'h7e;
    localparam logic [7:0]  ESC_BYTE         = 8'h7d;
    localparam logic [7:0]  ESC_XOR          = 8'h20;
    localparam logic [7:0]  FLOW_RESUME      = 8'h11;
    localparam logic [7:0]  FLOW_PAUSE       = 8'h13;
    localparam logic [7:0]  CSUM_BASE        = 8'hff;
    localparam logic [7:0]  CSUM_GOOD        = 8'hff;

    // Values after reset and the count step
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [15:0] LEN_RESET        = 16'h0000;
    localparam logic [15:0] LEN_ONE          = 16'h0001;

    typedef enum logic [2:0] {
        RX_HUNT   = 3'b000,
        RX_LEN_HI = 3'b001,
        RX_LEN_LO = 3'b010,
        RX_DATA   = 3'b011,
        RX_CSUM   = 3'b100
    } rx_state_e;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_LEN_HI = 3'b001,
        TX_LEN_LO = 3'b010,
        TX_DATA   = 3'b011,
        TX_CSUM   = 3'b100
    } tx_state_e;

    function automatic logic needs_escape(input logic [7:0] b);
        needs_escape = (b == START_DELIM) || (b == ESC_BYTE) || (b == FLOW_RESUME) || (b == FLOW_PAUSE);
    endfunction : needs_escape

    function automatic logic is_framed(input logic [1:0] mode);
        is_framed = (mode == MODE_FRAMED) || (mode == MODE_ESCAPED);
    endfunction : is_framed

endpackage : serial_api_frame_codec_pkg

// [rtl/serial_api_frame_codec.sv]
// Host serial byte stream framer and deframer
`timescale 1ns/1ps

// Notes on behaviour
// - Mode 0 transparent, 1 framed, 2 escaped
// - Transparent: every serial byte goes to radio
// - Transparent: radio payload sent raw, no framing
// - Framed: drop bytes until start delimiter
// - Bad frame: bytes already forwarded, o_tx_good low at o_tx_end, no host response
// - Escape is 0x7D then byte XOR 0x20
// - Escape only 7E, 7D, 11, 13
// - Checksum uses unescaped byte values
// - Checksum is 0xFF minus data sum
// - Accept when data plus checksum sum 0xFF
// - Length counts unescaped frame data only
// - Multi-byte values sent high byte first
// - First data byte is message type
module serial_api_frame_codec (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Configuration
    input  wire logic [1:0]  i_framing_mode_select,
    // Bytes from host serial receiver
    input  wire logic        i_ser_rx_valid,
    input  wire logic [7:0]  i_ser_rx_data,
    // Deframed bytes toward radio transmit path
    output logic             o_tx_valid,
    output logic [7:0]       o_tx_data,
    output logic             o_tx_end,
    output logic             o_tx_good,
    // Radio payload to be sent to host
    input  wire logic        i_rf_valid,
    input  wire logic [7:0]  i_rf_data,
    input  wire logic        i_rf_last,
    input  wire logic [15:0] i_rf_len,
    output logic             o_rf_ready,
    // Bytes toward host serial transmitter
    output logic             o_ser_tx_valid,
    output logic [7:0]       o_ser_tx_data,
    input  wire logic        i_ser_tx_ready
);

    // Receive group
    serial_api_frame_codec_pkg::rx_state_e rx_state_r;
    serial_api_frame_codec_pkg::rx_state_e rx_state_nxt;
    logic                    rx_esc_r;
    logic                    rx_esc_nxt;
    logic [7:0]              rx_len_hi_r;
    logic [7:0]              rx_len_hi_nxt;
    logic [15:0]             rx_len_r;
    logic [15:0]             rx_len_nxt;
    logic [15:0]             rx_cnt_r;
    logic [15:0]             rx_cnt_nxt;
    logic [7:0]              rx_sum_r;
    logic [7:0]              rx_sum_nxt;
    logic                    tx_valid_r;
    logic                    tx_valid_nxt;
    logic [7:0]              tx_data_r;
    logic [7:0]              tx_data_nxt;
    logic                    tx_end_r;
    logic                    tx_end_nxt;
    logic                    tx_good_r;
    logic                    tx_good_nxt;

    // Transmit group
    serial_api_frame_codec_pkg::tx_state_e tx_state_r;
    serial_api_frame_codec_pkg::tx_state_e tx_state_nxt;
    logic                    hold_valid_r;
    logic                    hold_valid_nxt;
    logic [7:0]              hold_data_r;
    logic [7:0]              hold_data_nxt;
    logic                    hold_last_r;
    logic                    hold_last_nxt;
    logic [15:0]             hold_len_r;
    logic [15:0]             hold_len_nxt;
    logic                    rf_ready_r;
    logic                    rf_ready_nxt;
    logic [15:0]             out_len_r;
    logic [15:0]             out_len_nxt;
    logic [7:0]              out_sum_r;
    logic [7:0]              out_sum_nxt;
    logic                    esc_pend_r;
    logic                    esc_pend_nxt;
    logic [7:0]              pend_byte_r;
    logic [7:0]              pend_byte_nxt;
    logic                    ser_valid_r;
    logic                    ser_valid_nxt;
    logic [7:0]              ser_data_r;
    logic [7:0]              ser_data_nxt;

    // Receive next state
    always_comb begin
        logic [7:0] v;
        v             = serial_api_frame_codec_pkg::BYTE_RESET;
        rx_state_nxt  = rx_state_r;
        rx_esc_nxt    = rx_esc_r;
        rx_len_hi_nxt = rx_len_hi_r;
        rx_len_nxt    = rx_len_r;
        rx_cnt_nxt    = rx_cnt_r;
        rx_sum_nxt    = rx_sum_r;
        tx_valid_nxt  = 1'b0;
        tx_data_nxt   = tx_data_r;
        tx_end_nxt    = 1'b0;
        tx_good_nxt   = 1'b0;
        if (!serial_api_frame_codec_pkg::is_framed(i_framing_mode_select)) begin
            // Leaving framed mode abandons any frame in progress
            if (rx_state_r != serial_api_frame_codec_pkg::RX_HUNT) begin
                tx_end_nxt = 1'b1;
            end
            rx_state_nxt = serial_api_frame_codec_pkg::RX_HUNT;
            rx_esc_nxt   = 1'b0;
            if (i_ser_rx_valid) begin
                tx_valid_nxt = 1'b1;
                tx_data_nxt  = i_ser_rx_data;
            end
        end else if (i_ser_rx_valid) begin
            if ((i_framing_mode_select == serial_api_frame_codec_pkg::MODE_ESCAPED)
                && (i_ser_rx_data == serial_api_frame_codec_pkg::START_DELIM)) begin
                // An unescaped delimiter can only mean a new frame
                if (rx_state_r != serial_api_frame_codec_pkg::RX_HUNT) begin
                    tx_end_nxt = 1'b1;
                end
                rx_state_nxt = serial_api_frame_codec_pkg::RX_LEN_HI;
                rx_esc_nxt   = 1'b0;
            end else if ((i_framing_mode_select == serial_api_frame_codec_pkg::MODE_ESCAPED)
                         && (i_ser_rx_data == serial_api_frame_codec_pkg::ESC_BYTE) && !rx_esc_r) begin
                rx_esc_nxt = 1'b1;
            end else begin
                v          = rx_esc_r ? (i_ser_rx_data ^ serial_api_frame_codec_pkg::ESC_XOR) : i_ser_rx_data;
                rx_esc_nxt = 1'b0;
                case (rx_state_r)
                    serial_api_frame_codec_pkg::RX_HUNT: begin
                        if (i_ser_rx_data == serial_api_frame_codec_pkg::START_DELIM) begin
                            rx_state_nxt = serial_api_frame_codec_pkg::RX_LEN_HI;
                        end
                    end
                    serial_api_frame_codec_pkg::RX_LEN_HI: begin
                        rx_len_hi_nxt = v;
                        rx_state_nxt  = serial_api_frame_codec_pkg::RX_LEN_LO;
                    end
                    serial_api_frame_codec_pkg::RX_LEN_LO: begin
                        rx_len_nxt = {rx_len_hi_r, v};
                        rx_cnt_nxt = serial_api_frame_codec_pkg::LEN_RESET;
                        rx_sum_nxt = serial_api_frame_codec_pkg::BYTE_RESET;
                        // No room for a message type byte: malformed, nothing was forwarded yet
                        if ({rx_len_hi_r, v} == serial_api_frame_codec_pkg::LEN_RESET) begin
                            rx_state_nxt = serial_api_frame_codec_pkg::RX_HUNT;
                        end else begin
                            rx_state_nxt = serial_api_frame_codec_pkg::RX_DATA;
                        end
                    end
                    serial_api_frame_codec_pkg::RX_DATA: begin
                        tx_valid_nxt = 1'b1;
                        tx_data_nxt  = v;
                        rx_sum_nxt   = rx_sum_r + v;
                        rx_cnt_nxt   = rx_cnt_r + serial_api_frame_codec_pkg::LEN_ONE;
                        if ((rx_cnt_r + serial_api_frame_codec_pkg::LEN_ONE) == rx_len_r) begin
                            rx_state_nxt = serial_api_frame_codec_pkg::RX_CSUM;
                        end
                    end
                    serial_api_frame_codec_pkg::RX_CSUM: begin
                        tx_end_nxt   = 1'b1;
                        tx_good_nxt  = ((rx_sum_r + v) == serial_api_frame_codec_pkg::CSUM_GOOD);
                        rx_state_nxt = serial_api_frame_codec_pkg::RX_HUNT;
                    end
                    default: begin
                        rx_state_nxt = serial_api_frame_codec_pkg::RX_HUNT;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_state_r  <= serial_api_frame_codec_pkg::RX_HUNT;
            rx_esc_r    <= 1'b0;
            rx_len_hi_r <= serial_api_frame_codec_pkg::BYTE_RESET;
            rx_len_r    <= serial_api_frame_codec_pkg::LEN_RESET;
            rx_cnt_r    <= serial_api_frame_codec_pkg::LEN_RESET;
            rx_sum_r    <= serial_api_frame_codec_pkg::BYTE_RESET;
            tx_valid_r  <= 1'b0;
            tx_data_r   <= serial_api_frame_codec_pkg::BYTE_RESET;
            tx_end_r    <= 1'b0;
            tx_good_r   <= 1'b0;
        end else begin
            rx_state_r  <= rx_state_nxt;
            rx_esc_r    <= rx_esc_nxt;
            rx_len_hi_r <= rx_len_hi_nxt;
            rx_len_r    <= rx_len_nxt;
            rx_cnt_r    <= rx_cnt_nxt;
            rx_sum_r    <= rx_sum_nxt;
            tx_valid_r  <= tx_valid_nxt;
            tx_data_r   <= tx_data_nxt;
            tx_end_r    <= tx_end_nxt;
            tx_good_r   <= tx_good_nxt;
        end
    end

    // Transmit next state
    always_comb begin
        logic       free;
        logic       consume;
        logic       send_req;
        logic       send_raw;
        logic [7:0] send_b;
        free           = !ser_valid_r || i_ser_tx_ready;
        consume        = 1'b0;
        send_req       = 1'b0;
        send_raw       = 1'b0;
        send_b         = serial_api_frame_codec_pkg::BYTE_RESET;
        tx_state_nxt   = tx_state_r;
        out_len_nxt    = out_len_r;
        out_sum_nxt    = out_sum_r;
        esc_pend_nxt   = esc_pend_r;
        pend_byte_nxt  = pend_byte_r;
        ser_valid_nxt  = ser_valid_r && !i_ser_tx_ready;
        ser_data_nxt   = ser_data_r;
        hold_data_nxt  = hold_data_r;
        hold_last_nxt  = hold_last_r;
        hold_len_nxt   = hold_len_r;
        if (free) begin
            if (esc_pend_r) begin
                send_req     = 1'b1;
                send_raw     = 1'b1;
                send_b       = pend_byte_r;
                esc_pend_nxt = 1'b0;
            end else begin
                case (tx_state_r)
                    serial_api_frame_codec_pkg::TX_IDLE: begin
                        if (hold_valid_r) begin
                            if (!serial_api_frame_codec_pkg::is_framed(i_framing_mode_select)) begin
                                send_req = 1'b1;
                                send_raw = 1'b1;
                                send_b   = hold_data_r;
                                consume  = 1'b1;
                            end else begin
                                send_req     = 1'b1;
                                send_raw     = 1'b1;
                                send_b       = serial_api_frame_codec_pkg::START_DELIM;
                                out_len_nxt  = hold_len_r;
                                out_sum_nxt  = serial_api_frame_codec_pkg::BYTE_RESET;
                                tx_state_nxt = serial_api_frame_codec_pkg::TX_LEN_HI;
                            end
                        end
                    end
                    serial_api_frame_codec_pkg::TX_LEN_HI: begin
                        send_req     = 1'b1;
                        send_b       = out_len_r[15:8];
                        tx_state_nxt = serial_api_frame_codec_pkg::TX_LEN_LO;
                    end
                    serial_api_frame_codec_pkg::TX_LEN_LO: begin
                        send_req     = 1'b1;
                        send_b       = out_len_r[7:0];
                        tx_state_nxt = serial_api_frame_codec_pkg::TX_DATA;
                    end
                    serial_api_frame_codec_pkg::TX_DATA: begin
                        if (hold_valid_r) begin
                            send_req    = 1'b1;
                            send_b      = hold_data_r;
                            out_sum_nxt = out_sum_r + hold_data_r;
                            consume     = 1'b1;
                            if (hold_last_r) begin
                                tx_state_nxt = serial_api_frame_codec_pkg::TX_CSUM;
                            end
                        end
                    end
                    serial_api_frame_codec_pkg::TX_CSUM: begin
                        send_req     = 1'b1;
                        send_b       = serial_api_frame_codec_pkg::CSUM_BASE - out_sum_r;
                        tx_state_nxt = serial_api_frame_codec_pkg::TX_IDLE;
                    end
                    default: begin
                        tx_state_nxt = serial_api_frame_codec_pkg::TX_IDLE;
                    end
                endcase
            end
        end
        if (send_req) begin
            ser_valid_nxt = 1'b1;
            // Escape after the checksum sum is taken, so the sum stays on raw values
            if (!send_raw && (i_framing_mode_select == serial_api_frame_codec_pkg::MODE_ESCAPED)
                && serial_api_frame_codec_pkg::needs_escape(send_b)) begin
                ser_data_nxt  = serial_api_frame_codec_pkg::ESC_BYTE;
                esc_pend_nxt  = 1'b1;
                pend_byte_nxt = send_b ^ serial_api_frame_codec_pkg::ESC_XOR;
            end else begin
                ser_data_nxt = send_b;
            end
        end
        // One byte holding stage keeps the ready output registered
        hold_valid_nxt = (hold_valid_r && !consume) || (i_rf_valid && rf_ready_r);
        if (i_rf_valid && rf_ready_r) begin
            hold_data_nxt = i_rf_data;
            hold_last_nxt = i_rf_last;
            hold_len_nxt  = i_rf_len;
        end
        rf_ready_nxt = !hold_valid_nxt;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_state_r   <= serial_api_frame_codec_pkg::TX_IDLE;
            hold_valid_r <= 1'b0;
            hold_data_r  <= serial_api_frame_codec_pkg::BYTE_RESET;
            hold_last_r  <= 1'b0;
            hold_len_r   <= serial_api_frame_codec_pkg::LEN_RESET;
            rf_ready_r   <= 1'b0;
            out_len_r    <= serial_api_frame_codec_pkg::LEN_RESET;
            out_sum_r    <= serial_api_frame_codec_pkg::BYTE_RESET;
            esc_pend_r   <= 1'b0;
            pend_byte_r  <= serial_api_frame_codec_pkg::BYTE_RESET;
            ser_valid_r  <= 1'b0;
            ser_data_r   <= serial_api_frame_codec_pkg::BYTE_RESET;
        end else begin
            tx_state_r   <= tx_state_nxt;
            hold_valid_r <= hold_valid_nxt;
            hold_data_r  <= hold_data_nxt;
            hold_last_r  <= hold_last_nxt;
            hold_len_r   <= hold_len_nxt;
            rf_ready_r   <= rf_ready_nxt;
            out_len_r    <= out_len_nxt;
            out_sum_r    <= out_sum_nxt;
            esc_pend_r   <= esc_pend_nxt;
            pend_byte_r  <= pend_byte_nxt;
            ser_valid_r  <= ser_valid_nxt;
            ser_data_r   <= ser_data_nxt;
        end
    end

    assign o_tx_valid     = tx_valid_r;
    assign o_tx_data      = tx_data_r;
    assign o_tx_end       = tx_end_r;
    assign o_tx_good      = tx_good_r;
    assign o_rf_ready     = rf_ready_r;
    assign o_ser_tx_valid = ser_valid_r;
    assign o_ser_tx_data  = ser_data_r;

endmodule : serial_api_frame_codec

// [dv/serial_api_frame_codec_assertions.sv]
// Port-level assertion checker for the serial frame codec
`timescale 1ns/1ps
module serial_api_frame_codec_checker (
    // Clock, reset, mode
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic [1:0]  i_framing_mode_select,
    // Host serial in and deframed out
    input wire logic        i_ser_rx_valid,
    input wire logic [7:0]  i_ser_rx_data,
    input wire logic        o_tx_valid,
    input wire logic [7:0]  o_tx_data,
    input wire logic        o_tx_end,
    input wire logic        o_tx_good,
    // Radio payload in and host serial out
    input wire logic        i_rf_valid,
    input wire logic [7:0]  i_rf_data,
    input wire logic        i_rf_last,
    input wire logic [15:0] i_rf_len,
    input wire logic        o_rf_ready,
    input wire logic        o_ser_tx_valid,
    input wire logic [7:0]  o_ser_tx_data,
    input wire logic        i_ser_tx_ready
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    logic [1:0] m;
    assign m = i_framing_mode_select;

    a_reset_quiet: assert property ($past(i_srst) |-> !o_tx_valid && !o_tx_end && !o_ser_tx_valid && !o_rf_ready)
        else $error("output active at first edge after reset");
    a_pass_through: assert property ((i_ser_rx_valid && m == 2'h0 && $past(m) == 2'h0) |=>
        o_tx_valid && o_tx_data == $past(i_ser_rx_data)) else $error("transparent byte not passed");
    a_tx_has_cause: assert property (o_tx_valid |-> $past(i_ser_rx_valid))
        else $error("deframed byte without serial input");
    a_end_has_cause: assert property (o_tx_end |-> $past(i_ser_rx_valid) || $past(m) != m || $past(m, 2) != $past(m))
        else $error("frame end without cause");
    a_good_needs_end: assert property (o_tx_good |-> o_tx_end)
        else $error("good flag outside frame end");
    a_escape_silent: assert property ((i_ser_rx_valid && m == 2'h2 && (i_ser_rx_data == 8'h7e || i_ser_rx_data == 8'h7d))
        |=> !o_tx_valid) else $error("escape or delimiter emitted as data");
    a_no_raw_flow: assert property ((o_ser_tx_valid && m == 2'h2) |-> o_ser_tx_data != 8'h11 && o_ser_tx_data != 8'h13)
        else $error("flow control byte sent unescaped");
    a_ser_hold: assert property ((o_ser_tx_valid && !i_ser_tx_ready) |=> o_ser_tx_valid && $stable(o_ser_tx_data))
        else $error("serial byte dropped before accept");
    a_rf_gap: assert property ((i_rf_valid && o_rf_ready) |=> !o_rf_ready)
        else $error("radio ready not dropped after take");
    a_raw_radio: assert property ((i_rf_valid && o_rf_ready && m == 2'h0 && !o_ser_tx_valid) |->
        ##2 (o_ser_tx_valid && o_ser_tx_data == $past(i_rf_data, 2))) else $error("transparent radio byte altered");
endmodule : serial_api_frame_codec_checker

bind serial_api_frame_codec serial_api_frame_codec_checker i_chk (.i_clk, .i_srst, .i_framing_mode_select,
    .i_ser_rx_valid, .i_ser_rx_data, .o_tx_valid, .o_tx_data, .o_tx_end, .o_tx_good, .i_rf_valid, .i_rf_data,
    .i_rf_last, .i_rf_len, .o_rf_ready, .o_ser_tx_valid, .o_ser_tx_data, .i_ser_tx_ready);

// [dv/host_serial_model.sv]
// Host processor model on the serial side of the codec
`timescale 1ns/1ps
module host_serial_model (
    input  wire logic       i_clk,
    // Bytes toward the codec
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    // Bytes from the codec
    output logic            o_tx_ready,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data
);
    logic       slow;
    int         phase;
    logic [7:0] got_q[$];

    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_tx_ready = 1'b1;
        slow       = 1'b0;
        phase      = 0;
    end

    // Slow mode accepts only every third cycle
    always @(posedge i_clk) begin
        if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) got_q.push_back(i_tx_data);
        phase++;
        #1;
        o_tx_ready = !slow || (phase % 3 == 0);
    end

    // Whole frame, already escaped by caller, back to back
    task automatic send(input logic [79:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            #1;
            o_rx_valid = 1'b1;
            o_rx_data  = v[79 - 8 * i -: 8];
        end
        @(posedge i_clk);
        #1;
        o_rx_valid = 1'b0;
        o_rx_data  = ~o_rx_data;
    endtask : send
endmodule : host_serial_model

// [dv/serial_api_frame_codec_test.sv]
// Self-checking bench for the serial frame codec
`timescale 1ns/1ps
module serial_api_frame_codec_test;
    typedef struct {
        logic [1:0]  m;
        logic [79:0] in;
        int          n_in;
        logic [31:0] out;
        int          n_out;
        logic [1:0]  ends;
        int          n_end;
    } row_s;

    logic        i_clk;
    logic        i_srst;
    logic [1:0]  i_framing_mode_select;
    logic        i_ser_rx_valid;
    logic [7:0]  i_ser_rx_data;
    logic        o_tx_valid;
    logic [7:0]  o_tx_data;
    logic        o_tx_end;
    logic        o_tx_good;
    logic        i_rf_valid;
    logic [7:0]  i_rf_data;
    logic        i_rf_last;
    logic [15:0] i_rf_len;
    logic        o_rf_ready;
    logic        o_ser_tx_valid;
    logic [7:0]  o_ser_tx_data;
    logic        i_ser_tx_ready;
    logic [7:0]  tx_q[$];
    logic        end_q[$];
    logic [7:0]  exp_q[$];
    int          n_mismatch;
    int          n_tests;

    // Ends listed low bit first: 1 means good
    row_s rows[10] = '{
        '{2'h1, 80'h7e00022311cb_00000000, 6, 32'h23110000, 2, 2'b01, 1},
        '{2'h2, 80'h7e0002237d31cb_000000, 7, 32'h23110000, 2, 2'b01, 1},
        '{2'h1, 80'h55137e00010af5_000000, 7, 32'h0a000000, 1, 2'b01, 1},
        '{2'h1, 80'h7e00010af4_0000000000, 5, 32'h0a000000, 1, 2'b00, 1},
        '{2'h0, 80'h7e7d11_00000000000000, 3, 32'h7e7d1100, 3, 2'b00, 0},
        '{2'h2, 80'h7e0001ee7d31_00000000, 6, 32'hee000000, 1, 2'b01, 1},
        '{2'h1, 80'h7e00017e81_0000000000, 5, 32'h7e000000, 1, 2'b01, 1},
        '{2'h2, 80'h7e0002237e00010af5_00, 9, 32'h230a0000, 2, 2'b10, 2},
        '{2'h1, 80'h7e0000ff_000000000000, 4, 32'h00000000, 0, 2'b00, 0},
        '{2'h3, 80'h417e_0000000000000000, 2, 32'h417e0000, 2, 2'b00, 0}
    };

    serial_api_frame_codec i_dut (.i_clk, .i_srst, .i_framing_mode_select, .i_ser_rx_valid, .i_ser_rx_data,
        .o_tx_valid, .o_tx_data, .o_tx_end, .o_tx_good, .i_rf_valid, .i_rf_data, .i_rf_last, .i_rf_len,
        .o_rf_ready, .o_ser_tx_valid, .o_ser_tx_data, .i_ser_tx_ready);

    host_serial_model i_host (.i_clk, .o_rx_valid(i_ser_rx_valid), .o_rx_data(i_ser_rx_data),
        .o_tx_ready(i_ser_tx_ready), .i_tx_valid(o_ser_tx_valid), .i_tx_data(o_ser_tx_data));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (i_srst === 1'b0 && o_tx_valid === 1'b1) tx_q.push_back(o_tx_data);
        if (i_srst === 1'b0 && o_tx_end === 1'b1) end_q.push_back(o_tx_good);
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic final_report();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic push_enc(input logic [7:0] b, input logic [1:0] m);
        if (m == 2'h2 && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
            exp_q.push_back(8'h7d);
            exp_q.push_back(b ^ 8'h20);
        end else begin
            exp_q.push_back(b);
        end
    endtask : push_enc

    // Radio payload of up to four bytes, expected host bytes built locally
    task automatic rf_frame(input logic [1:0] m, input logic [31:0] pl, input int n);
        logic [7:0] sum;
        int         k;
        sum = 8'h00;
        i_framing_mode_select = m;
        exp_q.delete();
        i_host.got_q.delete();
        if (m != 2'h0) begin
            exp_q.push_back(8'h7e);
            push_enc(8'h00, m);
            push_enc(n[7:0], m);
        end
        for (int i = 0; i < n; i++) begin
            sum = sum + pl[31 - 8 * i -: 8];
            push_enc(pl[31 - 8 * i -: 8], m);
        end
        if (m != 2'h0) push_enc(8'hff - sum, m);
        @(posedge i_clk);
        #1;
        for (int i = 0; i < n; i++) begin
            i_rf_valid = 1'b1;
            i_rf_data  = pl[31 - 8 * i -: 8];
            i_rf_last  = (i == n - 1);
            i_rf_len   = 16'(n);
            k = 0;
            do begin
                @(posedge i_clk);
                k++;
            end while (o_rf_ready !== 1'b1 && k < 100);
            if (o_rf_ready !== 1'b1) begin
                chk("rf_take", 16'h0001, 16'h0000);
                final_report();
            end
            #1;
        end
        i_rf_valid = 1'b0;
        i_rf_data  = ~i_rf_data;
        i_rf_last  = 1'b0;
        k = 0;
        while (i_host.got_q.size() < exp_q.size() && k < 400) begin
            @(posedge i_clk);
            k++;
        end
        if (i_host.got_q.size() < exp_q.size()) begin
            chk("ser_wait", 16'h0001, 16'h0000);
            final_report();
        end
        repeat (6) @(posedge i_clk);
        #1;
        chk("ser_count", exp_q.size(), i_host.got_q.size());
        for (int i = 0; i < exp_q.size() && i < i_host.got_q.size(); i++) begin
            chk("ser_byte", exp_q[i], i_host.got_q[i]);
        end
    endtask : rf_frame

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        i_srst = 1'b1;
        i_framing_mode_select = 2'h0;
        i_rf_valid = 1'b0;
        i_rf_data = 8'h00;
        i_rf_last = 1'b0;
        i_rf_len = 16'h0000;
        repeat (12) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        foreach (rows[r]) begin
            i_framing_mode_select = rows[r].m;
            repeat (2) @(posedge i_clk);
            tx_q.delete();
            end_q.delete();
            i_host.send(rows[r].in, rows[r].n_in);
            repeat (4) @(posedge i_clk);
            #1;
            chk("tx_count", rows[r].n_out, tx_q.size());
            chk("end_count", rows[r].n_end, end_q.size());
            for (int i = 0; i < tx_q.size() && i < rows[r].n_out; i++) begin
                chk("tx_byte", rows[r].out[31 - 8 * i -: 8], tx_q[i]);
            end
            for (int i = 0; i < end_q.size() && i < rows[r].n_end; i++) begin
                chk("end_good", rows[r].ends[i], end_q[i]);
            end
        end
        rf_frame(2'h1, 32'h23110000, 2);
        rf_frame(2'h2, 32'h23110000, 2);
        i_host.slow = 1'b1;
        rf_frame(2'h2, 32'hee000000, 1);
        rf_frame(2'h2, 32'h7d7e1300, 3);
        rf_frame(2'h1, 32'h7d7e1300, 3);
        rf_frame(2'h0, 32'h7e110000, 2);
        i_host.slow = 1'b0;
        // Leaving framed mode mid-frame must flag the partial frame bad
        i_framing_mode_select = 2'h1;
        end_q.delete();
        i_host.send(80'h7e000223_000000000000, 4);
        i_framing_mode_select = 2'h0;
        repeat (3) @(posedge i_clk);
        chk("exit_ends", 16'h0001, end_q.size());
        if (end_q.size() == 1) chk("exit_good", 16'h0000, {15'h0000, end_q[0]});
        #1;
        i_srst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        @(posedge i_clk);
        #1;
        chk("rst_outputs", 16'h0001, {13'h0000, o_tx_valid, o_ser_tx_valid, o_rf_ready});
        repeat (3) @(posedge i_clk);
        chk("rst_ready", 16'h0001, {15'h0000, o_rf_ready});
        final_report();
    end
endmodule : serial_api_frame_codec_test
